// >>> mpct_ahb.v
// AHB-Lite slave front end: address phase capture and single-cycle answer
`timescale 1ns/1ps

module mpct_ahb
(
    input  wire        clk_i,
    input  wire        reset_n_i,
    input  wire        hsel_i,
    input  wire [7:0]  haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire        hready_i,
    output reg         wr_r,
    output reg         rd_r,
    output reg  [7:0]  addr_r
);

`include "mpct_map.vh"

    wire take;

    assign take = hsel_i && hready_i && htrans_i[1];

    // Latch address phase; data phase follows with zero wait states
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wr_r   <= 1'b0;
            rd_r   <= 1'b0;
            addr_r <= `MPCT_RST8;
        end
        else
        begin
            wr_r <= take && hwrite_i;
            rd_r <= take && !hwrite_i;
            if (take)
                addr_r <= haddr_i;
        end
    end

endmodule // mpct_ahb

// >>> mpct_chan.v
// One timer channel: counter, four comparators, flags and pins
`timescale 1ns/1ps

module mpct_chan
(
    input  wire        clk_i,
    input  wire        reset_n_i,
    input  wire        run_i,
    input  wire [1:0]  clr_sel_i,
    input  wire [3:0]  irq_en_i,
    input  wire [3:0]  flag_clr_i,
    input  wire [63:0] cmp_i,
    input  wire [2:0]  init_lvl_i,
    input  wire        pin_load_i,
    output reg  [15:0] count_r,
    output reg  [3:0]  flag_r,
    output reg  [2:0]  pin_r,
    output wire        irq_o
);

`include "mpct_map.vh"

    reg  [15:0] count_nxt;
    reg         clear_hit;
    wire [3:0]  match;

    // ======================================================================
    // Compare detection, one comparator per register
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_cmp
            assign match[g] = run_i && (count_r == cmp_i[g*16 +: 16]);
        end
    endgenerate

    // Clear source decode and next count
    always @*
    begin
        case (clr_sel_i)
            `MPCT_CLR_A:  clear_hit = match[0];
            `MPCT_CLR_B:  clear_hit = match[1];
            `MPCT_CLR_CD: clear_hit = match[2] | match[3];
            default:      clear_hit = 1'b0;
        endcase
        if (!run_i)
            count_nxt = count_r;
        else if (clear_hit)
            count_nxt = `MPCT_RST16;
        else
            count_nxt = count_r + `MPCT_ONE16;
    end

    // Counter register
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            count_r <= `MPCT_RST16;
        else
            count_r <= count_nxt;
    end

    // Sticky match flags, set wins over a clear by read
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            flag_r <= 4'h0;
        else
            flag_r <= (flag_r & ~flag_clr_i) | match;
    end

    // Compare pins: initial level loaded, toggled on each match of compare B..D
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            pin_r <= 3'h0;
        else if (pin_load_i)
            pin_r <= init_lvl_i;
        else
            pin_r <= pin_r ^ match[3:1];
    end

    assign irq_o = |(flag_r & irq_en_i);

endmodule // mpct_chan

// >>> mpct_load.sv
// Behavioural load on the channel-1 compare pins
`timescale 1ns/1ps

// ==========
// Pin load
module mpct_load
(
    input  logic       clk_i,
    input  logic [2:0] pin_i,
    output int         flips_o
);
    logic [2:0] last_r = 3'h0;

    // Count every level change the load sees
    always @(posedge clk_i)
    begin
        flips_o <= flips_o + $countones(pin_i ^ last_r);
        last_r <= pin_i;
    end

    initial flips_o = 0;
endmodule // mpct_load

// >>> mpct_map.vh
// Register map, field positions and reset values of the periodic timer
`ifndef MPCT_MAP_VH
`define MPCT_MAP_VH

// ==========================================================================
// Register byte offsets
`define MPCT_OFS_START      8'h00
`define MPCT_OFS_CTRL0      8'h04
`define MPCT_OFS_CTRL1      8'h08
`define MPCT_OFS_IRQEN0     8'h0C
`define MPCT_OFS_IRQEN1     8'h10
`define MPCT_OFS_STATUS0    8'h14
`define MPCT_OFS_STATUS1    8'h18
`define MPCT_OFS_COUNT0     8'h1C
`define MPCT_OFS_COUNT1     8'h20
`define MPCT_OFS_INITLVL    8'h24
`define MPCT_OFS_PWMFN      8'h28
`define MPCT_OFS_CMP0       8'h40
`define MPCT_OFS_CMP1       8'h50

// ==========================================================================
// Field positions
`define MPCT_INIT_D_BIT     7
`define MPCT_INIT_C_BIT     6
`define MPCT_INIT_B_BIT     5
`define MPCT_CLR_HI_BIT     6
`define MPCT_CLR_LO_BIT     5
`define MPCT_PWM_MODE_HI    2
`define MPCT_PWM_MODE_LO    0
`define MPCT_PWM_INITIAL_LEVEL_SEL_1_BIT       5
`define MPCT_PWM_INITIAL_LEVEL_SEL_0_BIT       4

// ==========================================================================
// Encodings and reset values
`define MPCT_CLR_NONE       2'h0
`define MPCT_CLR_A          2'h1
`define MPCT_CLR_B          2'h2
`define MPCT_CLR_CD         2'h3
`define MPCT_PWM_RSYNC      3'h2
`define MPCT_PWM_COMPL      3'h4
`define MPCT_RST8           8'h00
`define MPCT_RST2           2'h0
`define MPCT_RST4           4'h0
`define MPCT_CMP_REGION     3'h2
`define MPCT_RST16          16'h0000
`define MPCT_CMP_RST        16'hFFFF
`define MPCT_ONE16          16'h0001
`define MPCT_HTRANS_NONSEQ  2'h2

`endif

// >>> mpct_tb.sv
// Self-checking bench for the periodic compare timer
`timescale 1ns/1ps
`include "mpct_map.vh"

// ==========
// Bench
module multichannel_periodic_compare_timer_tb;
    typedef struct packed {logic [7:0] a; logic [31:0] w, e;} mpct_row_t;
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        hsel_i = 1'b0;
    logic        hwrite_i = 1'b0;
    logic [7:0]  haddr_i = 8'h00;
    logic [1:0]  htrans_i = 2'h0;
    logic [2:0]  hsize_i = 3'h2;
    logic [31:0] hwdata_i = 32'h0, q, v;
    wire  [31:0] hrdata_o;
    wire         hreadyout_o, hresp_o, irq_o;
    wire         ch1_compare_pin_d_o, ch1_compare_pin_c_o;
    wire         ch1_compare_pin_b_o;
    wire         hready_i = hreadyout_o;
    wire  [2:0]  pins = {ch1_compare_pin_d_o, ch1_compare_pin_c_o,
                         ch1_compare_pin_b_o};
    int          err_count = 0, check_count = 0, cyc = 0, t1, flips;
    // Compare A is set up before counting starts
    mpct_row_t   rows [6] = '{
        '{`MPCT_OFS_INITLVL, 32'hE0, 32'hE0},
        '{`MPCT_OFS_CMP1, 32'h9, 32'h9},
        '{`MPCT_OFS_CTRL1, 32'h20, 32'h20},
        '{`MPCT_OFS_IRQEN1, 32'h1, 32'h1},
        '{`MPCT_OFS_COUNT1, 32'h1234, 32'h0},
        '{8'h3C, 32'hFFFF_FFFF, 32'h0}};

    mpct_top dut (.*);
    mpct_load u_load (.clk_i(clk_i), .pin_i(pins), .flips_o(flips));

    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One single transfer; read data is taken at the data phase edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        hsel_i <= 1'b1;
        haddr_i <= a;
        htrans_i <= `MPCT_HTRANS_NONSEQ;
        hwrite_i <= w;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        q = hrdata_o;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask

    task wirq();
        for (int n = 0; n < 100 && irq_o !== 1'b1; n++)
            @(posedge clk_i);
    endtask

    task print_verdict();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        repeat (5000) @(posedge clk_i);
        err_count++;
        print_verdict();
    end

    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rd(`MPCT_OFS_INITLVL, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].e);
        end
        wr(`MPCT_OFS_START, 32'h2);
        repeat (3) @(posedge clk_i);
        chk(pins, 3'h7);
        wirq();
        t1 = cyc;
        rd(`MPCT_OFS_STATUS1, 32'h1);
        repeat (3) @(posedge clk_i);
        chk(irq_o, 1'b0);
        wirq();
        chk(cyc - t1, 10);
        wr(`MPCT_OFS_IRQEN1, 32'h0);
        rd(`MPCT_OFS_STATUS1, 32'h1);
        repeat (12) @(posedge clk_i);
        chk(irq_o, 1'b0);
        wr(`MPCT_OFS_IRQEN1, 32'h1);
        repeat (2) @(posedge clk_i);
        chk(irq_o, 1'b1);
        wr(`MPCT_OFS_START, 32'h0);
        bus(1'b0, `MPCT_OFS_COUNT1, 32'h0);
        v = q;
        chk(v < 10, 1'b1);
        repeat (5) @(posedge clk_i);
        rd(`MPCT_OFS_COUNT1, v);
        // Both PWM modes take the pin levels from the PWM control
        for (int m = 0; m < 2; m++)
        begin
            wr(`MPCT_OFS_PWMFN, m ? 32'h14 : 32'h22);
            wr(`MPCT_OFS_START, 32'h2);
            repeat (3) @(posedge clk_i);
            chk(pins, m ? 3'h3 : 3'h4);
            wr(`MPCT_OFS_START, 32'h0);
        end
        // Channel 0 cleared by compare D, period five cycles
        wr(`MPCT_OFS_CTRL0, 32'h60);
        wr(`MPCT_OFS_CMP0 + 8'hC, 32'h4);
        wr(`MPCT_OFS_START, 32'h1);
        repeat (20) @(posedge clk_i);
        wr(`MPCT_OFS_START, 32'h0);
        rd(`MPCT_OFS_STATUS0, 32'h8);
        bus(1'b0, `MPCT_OFS_COUNT0, 32'h0);
        chk(q < 5, 1'b1);
        wr(`MPCT_OFS_START, 32'h2);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(pins, 3'h0);
        chk(irq_o, 1'b0);
        reset_n_i <= 1'b1;
        rd(`MPCT_OFS_INITLVL, 32'h0);
        rd(`MPCT_OFS_COUNT1, 32'h0);
        chk(flips, 10);
        print_verdict();
    end
endmodule // multichannel_periodic_compare_timer_tb

bind mpct_top mpct_top_mon u_mon (.*);

// >>> mpct_top.v
// Two-channel periodic compare timer with AHB-Lite register access
//
// Our own choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps

module mpct_top
(
    input  wire        clk_i,
    input  wire        reset_n_i,
    input  wire        hsel_i,
    input  wire [7:0]  haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [2:0]  hsize_i,
    input  wire        hready_i,
    input  wire [31:0] hwdata_i,
    output reg  [31:0] hrdata_o,
    output reg         hreadyout_o,
    output reg         hresp_o,
    output reg         irq_o,
    output reg         ch1_compare_pin_d_o,
    output reg         ch1_compare_pin_c_o,
    output reg         ch1_compare_pin_b_o
);

`include "mpct_map.vh"

    // ======================================================================
    // Registers
    // Map: 0x00 start, 0x04/0x08 control, 0x0C/0x10 irq enable,
    // 0x14/0x18 status (clear on read), 0x1C/0x20 count (read only),
    // 0x24 initial level, 0x28 PWM control, 0x40/0x50 compare A..D
    reg  [1:0]   counter_start_r;
    reg  [7:0]   ctrl0_r;
    reg  [7:0]   ctrl1_r;
    reg  [3:0]   irq_en0_r;
    reg  [3:0]   irq_en1_r;
    reg  [7:0]   output_initial_level_ctrl_r;
    reg  [7:0]   pwm_function_ctrl_r;
    reg  [127:0] cmp_r;
    reg  [31:0]  rdata_nxt;
    reg  [3:0]   clr0_nxt;
    reg  [3:0]   clr1_nxt;

    wire         wr;
    wire         rd;
    wire [7:0]   addr;
    wire [15:0]  count0;
    wire [15:0]  count1;
    wire [3:0]   flag0;
    wire [3:0]   flag1;
    wire [2:0]   pins1;
    wire         irq0;
    wire         irq1;
    wire         pwm_mode;
    wire [2:0]   init_lvl1;
    wire [1:0]   start_rise;
    reg  [1:0]   start_d_r;

    // Decoded bus strobes
    wire         bus_take;
    wire         rd_take;
    wire         wr_start;
    wire         wr_ctrl0;
    wire         wr_ctrl1;
    wire         wr_irqen0;
    wire         wr_irqen1;
    wire         wr_initlvl;
    wire         wr_pwmfn;
    wire         wr_cmp;
    wire         rd_status0;
    wire         rd_status1;

    // ======================================================================
    // Bus front end; hsize_i is not decoded, only whole words are served
    mpct_ahb u_ahb
    (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .hsel_i    (hsel_i),
        .haddr_i   (haddr_i),
        .htrans_i  (htrans_i),
        .hwrite_i  (hwrite_i),
        .hready_i  (hready_i),
        .wr_r      (wr),
        .rd_r      (rd),
        .addr_r    (addr)
    );

    // ======================================================================
    // Data-phase write strobes and status read strobes, one per register, one shared by all compare registers
    assign wr_start   = wr && (addr == `MPCT_OFS_START);
    assign wr_ctrl0   = wr && (addr == `MPCT_OFS_CTRL0);
    assign wr_ctrl1   = wr && (addr == `MPCT_OFS_CTRL1);
    assign wr_irqen0  = wr && (addr == `MPCT_OFS_IRQEN0);
    assign wr_irqen1  = wr && (addr == `MPCT_OFS_IRQEN1);
    assign wr_initlvl = wr && (addr == `MPCT_OFS_INITLVL);
    assign wr_pwmfn   = wr && (addr == `MPCT_OFS_PWMFN);
    assign wr_cmp     = wr && (addr[7:5] == `MPCT_CMP_REGION);
    assign rd_status0 = rd && (addr == `MPCT_OFS_STATUS0);
    assign rd_status1 = rd && (addr == `MPCT_OFS_STATUS1);

    // Counter start bits: bit 0 runs channel 0, bit 1 channel 1
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            counter_start_r <= `MPCT_RST2;
        else if (wr_start)
            counter_start_r <= hwdata_i[1:0];
    end

    // Channel 0 control, clear source select in bits 6 and 5
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            ctrl0_r <= `MPCT_RST8;
        else if (wr_ctrl0)
            ctrl0_r <= hwdata_i[7:0];
    end

    // Channel 1 control, same layout as channel 0
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            ctrl1_r <= `MPCT_RST8;
        else if (wr_ctrl1)
            ctrl1_r <= hwdata_i[7:0];
    end

    // Channel 0 match interrupt enables A..D
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            irq_en0_r <= `MPCT_RST4;
        else if (wr_irqen0)
            irq_en0_r <= hwdata_i[3:0];
    end

    // Channel 1 match interrupt enables A..D
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            irq_en1_r <= `MPCT_RST4;
        else if (wr_irqen1)
            irq_en1_r <= hwdata_i[3:0];
    end

    // Initial pin levels of channel 1, all low out of reset
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            output_initial_level_ctrl_r <= `MPCT_RST8;
        else if (wr_initlvl)
            output_initial_level_ctrl_r <= hwdata_i[7:0];
    end

    // PWM mode and the PWM initial level bits
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            pwm_function_ctrl_r <= `MPCT_RST8;
        else if (wr_pwmfn)
            pwm_function_ctrl_r <= hwdata_i[7:0];
    end

    // Compare registers, ch0 A..D then ch1 A..D, 16 bits each
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            cmp_r <= {8{`MPCT_CMP_RST}};
        else if (wr_cmp)
            cmp_r[{addr[4:2], 4'h0} +: 16] <= hwdata_i[15:0];
    end

    // ======================================================================
    // Start edge detector loads initial pin levels
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            start_d_r <= 2'h0;
        else
            start_d_r <= counter_start_r;
    end

    assign start_rise = counter_start_r & ~start_d_r;

    // Initial level source: PWM bits override in the two PWM modes
    assign pwm_mode =
        (pwm_function_ctrl_r[`MPCT_PWM_MODE_HI:`MPCT_PWM_MODE_LO]
            == `MPCT_PWM_RSYNC) ||
        (pwm_function_ctrl_r[`MPCT_PWM_MODE_HI:`MPCT_PWM_MODE_LO]
            == `MPCT_PWM_COMPL);
    assign init_lvl1 = pwm_mode ?
        {pwm_function_ctrl_r[`MPCT_PWM_INITIAL_LEVEL_SEL_1_BIT],
         pwm_function_ctrl_r[`MPCT_PWM_INITIAL_LEVEL_SEL_0_BIT],
         pwm_function_ctrl_r[`MPCT_PWM_INITIAL_LEVEL_SEL_0_BIT]} :
        {output_initial_level_ctrl_r[`MPCT_INIT_D_BIT],
         output_initial_level_ctrl_r[`MPCT_INIT_C_BIT],
         output_initial_level_ctrl_r[`MPCT_INIT_B_BIT]};

    // ======================================================================
    // Channels
    // Channel 0 counts and flags only; its compare pins stay internal
    mpct_chan u_ch0
    (
        .clk_i      (clk_i),
        .reset_n_i  (reset_n_i),
        .run_i      (counter_start_r[0]),
        .clr_sel_i  ({ctrl0_r[`MPCT_CLR_HI_BIT], ctrl0_r[`MPCT_CLR_LO_BIT]}),
        .irq_en_i   (irq_en0_r),
        .flag_clr_i (clr0_nxt),
        .cmp_i      (cmp_r[63:0]),
        .init_lvl_i (3'h0),
        .pin_load_i (start_rise[0]),
        .count_r    (count0),
        .flag_r     (flag0),
        .pin_r      (),
        .irq_o      (irq0)
    );

    mpct_chan u_ch1
    (
        .clk_i      (clk_i),
        .reset_n_i  (reset_n_i),
        .run_i      (counter_start_r[1]),
        .clr_sel_i  ({ctrl1_r[`MPCT_CLR_HI_BIT], ctrl1_r[`MPCT_CLR_LO_BIT]}),
        .irq_en_i   (irq_en1_r),
        .flag_clr_i (clr1_nxt),
        .cmp_i      (cmp_r[127:64]),
        .init_lvl_i (init_lvl1),
        .pin_load_i (start_rise[1]),
        .count_r    (count1),
        .flag_r     (flag1),
        .pin_r      (pins1),
        .irq_o      (irq1)
    );

    // ======================================================================
    // Address-phase qualifier of a read; with no wait states the read
    // data must be registered here to stand in the data phase
    assign bus_take = hsel_i && hready_i && htrans_i[1];
    assign rd_take  = bus_take && !hwrite_i;

    // Read mux on the address phase
    always @*
    begin
        rdata_nxt = 32'h0000_0000;
        case (haddr_i)
            `MPCT_OFS_START:   rdata_nxt[1:0] = counter_start_r;
            `MPCT_OFS_CTRL0:   rdata_nxt[7:0] = ctrl0_r;
            `MPCT_OFS_CTRL1:   rdata_nxt[7:0] = ctrl1_r;
            `MPCT_OFS_IRQEN0:  rdata_nxt[3:0] = irq_en0_r;
            `MPCT_OFS_IRQEN1:  rdata_nxt[3:0] = irq_en1_r;
            `MPCT_OFS_STATUS0: rdata_nxt[3:0] = flag0;
            `MPCT_OFS_STATUS1: rdata_nxt[3:0] = flag1;
            `MPCT_OFS_COUNT0:  rdata_nxt[15:0] = count0;
            `MPCT_OFS_COUNT1:  rdata_nxt[15:0] = count1;
            `MPCT_OFS_INITLVL: rdata_nxt[7:0] = output_initial_level_ctrl_r;
            `MPCT_OFS_PWMFN:   rdata_nxt[7:0] = pwm_function_ctrl_r;
            default:
            begin
                if (haddr_i[7:5] == `MPCT_CMP_REGION)
                    rdata_nxt[15:0] = cmp_r[{haddr_i[4:2], 4'h0} +: 16];
            end
        endcase
    end

    // Clear on read takes only the flags that the read reported, so a
    // match landing during the transfer is kept for the next read
    always @*
    begin
        clr0_nxt = `MPCT_RST4;
        clr1_nxt = `MPCT_RST4;
        if (rd_status0)
            clr0_nxt = hrdata_o[3:0];
        if (rd_status1)
            clr1_nxt = hrdata_o[3:0];
    end

    // ======================================================================
    // Bus answer: zero wait states, always OKAY, read data captured at
    // the address phase edge and cleared again after the data phase
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            hrdata_o    <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
        else
        begin
            hrdata_o    <= rd_take ? rdata_nxt : 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

    // Interrupt line: any unmasked flag of either channel
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            irq_o <= 1'b0;
        else
            irq_o <= irq0 | irq1;
    end

    // Channel-1 compare pins, one register stage to the outputs
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ch1_compare_pin_d_o <= 1'b0;
            ch1_compare_pin_c_o <= 1'b0;
            ch1_compare_pin_b_o <= 1'b0;
        end
        else
        begin
            ch1_compare_pin_d_o <= pins1[2];
            ch1_compare_pin_c_o <= pins1[1];
            ch1_compare_pin_b_o <= pins1[0];
        end
    end

endmodule // mpct_top

// >>> mpct_top_monitor.sv
// Port checker for the periodic compare timer
`timescale 1ns/1ps
`include "mpct_map.vh"

// ==========
// Checker
module mpct_top_mon
(
    input logic        clk_i,
    input logic        reset_n_i,
    input logic        hsel_i,
    input logic [7:0]  haddr_i,
    input logic [1:0]  htrans_i,
    input logic        hwrite_i,
    input logic        hready_i,
    input logic [31:0] hwdata_i,
    input logic        hreadyout_o,
    input logic        hresp_o,
    input logic        irq_o,
    input logic        ch1_compare_pin_d_o,
    input logic        ch1_compare_pin_c_o,
    input logic        ch1_compare_pin_b_o
);
    logic       aw_r, pwm_r, ea_r;
    logic [7:0] aa_r, en_r;
    logic [2:0] il_r, tk_r, sh_r;
    logic [1:0] st_r, ol_r;
    wire        tk = hsel_i && hready_i && htrans_i[1];
    wire        wd = aw_r && aa_r == `MPCT_OFS_START;
    wire        ld = wd && hwdata_i[1] && !st_r[1];
    wire        idle = st_r == 0 && sh_r == 0 && tk_r == 0 && !tk;
    wire [2:0]  pins = {ch1_compare_pin_d_o, ch1_compare_pin_c_o,
                        ch1_compare_pin_b_o};

    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    // Shadow copies of the written control fields
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            {aw_r, pwm_r, ea_r, aa_r, en_r} <= '0;
            {il_r, tk_r, sh_r, st_r, ol_r} <= '0;
        end
        else
        begin
            aw_r <= tk && hwrite_i;
            aa_r <= haddr_i;
            tk_r <= {tk_r[1:0], tk};
            sh_r <= {sh_r[1:0], |st_r};
            ea_r <= |en_r;
            if (wd)
                st_r <= hwdata_i[1:0];
            if (aw_r && aa_r == `MPCT_OFS_IRQEN0)
                en_r[3:0] <= hwdata_i[3:0];
            if (aw_r && aa_r == `MPCT_OFS_IRQEN1)
                en_r[7:4] <= hwdata_i[3:0];
            if (aw_r && aa_r == `MPCT_OFS_INITLVL)
                il_r <= hwdata_i[7:5];
            if (aw_r && aa_r == `MPCT_OFS_PWMFN)
            begin
                pwm_r <= hwdata_i[2:0] == `MPCT_PWM_RSYNC
                      || hwdata_i[2:0] == `MPCT_PWM_COMPL;
                ol_r <= hwdata_i[5:4];
            end
        end
    end

    property p_init_load;
        ld && !pwm_r |-> ##[1:4] pins == il_r;
    endproperty
    a_init_load: assert property (p_init_load)
        else $error("pins miss initial levels");
    property p_pwm_load;
        ld && pwm_r |-> ##[1:4] pins == {ol_r[1], ol_r[0], ol_r[0]};
    endproperty
    a_pwm_load: assert property (p_pwm_load)
        else $error("pins miss pwm levels");
    property p_no_en;
        !(|en_r) && !ea_r |-> !irq_o;
    endproperty
    a_no_en: assert property (p_no_en)
        else $error("irq without enable");
    property p_sticky;
        irq_o && tk_r == 0 && !tk |=> irq_o;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("irq dropped unprompted");
    property p_stop_pins;
        idle |=> $stable(pins);
    endproperty
    a_stop_pins: assert property (p_stop_pins)
        else $error("pins moved while stopped");
    property p_stop_irq;
        idle |=> !$rose(irq_o);
    endproperty
    a_stop_irq: assert property (p_stop_irq)
        else $error("irq rose while stopped");
    property p_ready;
        hreadyout_o;
    endproperty
    a_ready: assert property (p_ready)
        else $error("wait state seen");
    property p_okay;
        !hresp_o;
    endproperty
    a_okay: assert property (p_okay)
        else $error("error response seen");
endmodule // mpct_top_mon
